// [scp_pkg.sv]
package scp_pkg;
   // register map, byte-wide registers on the plain port
   localparam logic [7:0] ADDR_PRESCALE = 8'h00;
   localparam logic [7:0] ADDR_SLEEP = 8'h01;

   // prescale register layout
   localparam int UNLOCK_BIT = 7;
   localparam int DIV_LSB = 0;
   localparam int DIV_W = 4;
   localparam logic [7:0] UNLOCK_ONLY = 8'h80;
   localparam logic [3:0] DIV_RST_PLAIN = 4'h0;
   localparam logic [3:0] DIV_RST_FUSE = 4'h3;
   localparam logic [3:0] DIV_MAX = 4'h8;

   // sleep register layout
   localparam int ARM_BIT = 0;
   localparam int MODE_LSB = 1;
   localparam int MODE_W = 3;
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_ADC_NR = 3'h1;
   localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
   localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
   localparam logic [2:0] MODE_STANDBY = 3'h6;

   // timing, in master clock cycles
   localparam logic [2:0] UNLOCK_CYC = 3'h4;
   localparam logic [15:0] WAKE_HALT_CYC = 16'h0004;
   localparam logic [15:0] STANDBY_START_CYC = 16'h0006;
   localparam int STARTUP_CYC_DEFAULT = 16384;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // clock domain run mask bit positions
   localparam int DOM_CPU = 0;
   localparam int DOM_FLASH = 1;
   localparam int DOM_IO = 2;
   localparam int DOM_ADC = 3;
   localparam int DOM_ASY = 4;
   localparam int DOM_OSC = 5;
   localparam int DOM_W = 6;
   localparam logic [5:0] DOM_ALL = 6'h3f;
   localparam logic [5:0] DOM_NONE = 6'h00;

   // synchroniser lanes
   localparam int SYN_WAKE = 0;
   localparam int SYN_FUSE = 1;
   localparam int SYN_W = 2;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_SLEEP,
      ST_START,
      ST_HALT
   } scp_state_t;
endpackage

// [scp_link_if.sv]
`timescale 1ns/10ps
interface scp_link_if;
   import scp_pkg::*;
   logic [DIV_W-1:0] div_code;
   logic div_load;
   logic tick;
   logic [SYN_W-1:0] raw;
   logic [SYN_W-1:0] sync;

   modport div (input div_code, input div_load, output tick);
   modport syn (input raw, output sync);
   modport ctl (output div_code, output div_load, output raw, input tick, input sync);
endinterface

// [scp_clk_div.sv]
`timescale 1ns/10ps
module scp_clk_div
   import scp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   scp_link_if.div lnk
);
   logic [7:0] cnt_r;
   logic [DIV_W-1:0] cur_r;
   logic [DIV_W-1:0] pend_r;
   logic pend_valid_r;
   logic [7:0] limit;

   // factor is 2**code; tick ends each divided period
   assign limit = 8'((9'h001 << cur_r) - 9'h001);
   assign lnk.tick = (cnt_r == limit);

   // a new code waits for the end of the running period, so no period
   // is ever cut short by a change
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pend_r <= DIV_RST_PLAIN;
         pend_valid_r <= 1'b0;
      end else if (lnk.div_load) begin
         pend_r <= lnk.div_code;
         pend_valid_r <= 1'b1;
      end else if (lnk.tick) begin
         pend_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_r <= 8'h00;
         cur_r <= DIV_RST_PLAIN;
      end else if (lnk.tick) begin
         cnt_r <= 8'h00;
         if (pend_valid_r) begin
            cur_r <= pend_r;
         end
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule

// [scp_sync.sv]
`timescale 1ns/10ps
module scp_sync
   import scp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   scp_link_if.syn lnk
);
   genvar g;
   generate
      for (g = 0; g < SYN_W; g++) begin : g_lane
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic out_r;
         always_ff @(posedge i_ref_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               out_r <= 1'b0;
            end else begin
               s1_r <= lnk.raw[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               // follow only once the last two stages agree
               if (s2_r == s3_r) begin
                  out_r <= s3_r;
               end
            end
         end
         assign lnk.sync[g] = out_r;
      end
   endgenerate
endmodule

// [scp_top.sv]
`timescale 1ns/10ps
module scp_top
   import scp_pkg::*;
#(
   parameter int STARTUP_CYC = STARTUP_CYC_DEFAULT
)
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_sleep_instr,
   input wire logic i_wake_irq,
   input wire logic i_adc_enabled,
   input wire logic i_reset_div8_fuse,
   output logic o_clk_en_cpu,
   output logic o_clk_en_flash,
   output logic o_clk_en_io,
   output logic o_clk_en_adc,
   output logic o_clk_en_asy,
   output logic o_osc_en,
   output logic o_core_halt,
   output logic o_irq_go,
   output logic o_adc_auto_start
);
   scp_link_if lnk ();

   scp_clk_div u_div (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .lnk(lnk.div)
   );

   scp_sync u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .lnk(lnk.syn)
   );

   assign lnk.raw[SYN_WAKE] = i_wake_irq;
   assign lnk.raw[SYN_FUSE] = i_reset_div8_fuse;

   logic wr_pre;
   logic wr_slp;
   logic unlock_r;
   logic [2:0] unlock_cnt_r;
   logic [DIV_W-1:0] div_r;
   logic div_load_r;
   logic [1:0] strap_cnt_r;
   logic strap_done_r;
   logic strap_load_r;
   logic unlock_set;
   logic div_wr;
   logic div_ok;
   logic arm_r;
   logic [MODE_W-1:0] mode_r;
   logic [MODE_W-1:0] act_mode_r;
   scp_state_t state_r;
   scp_state_t state_nxt;
   logic [15:0] wait_r;
   logic [15:0] wait_nxt;
   logic [DOM_W-1:0] run_mask;
   logic sleep_go;
   logic wake;
   logic [7:0] rdata_r;
   logic irq_go_r;
   logic adc_start_r;

   assign wr_pre = i_wr && (i_addr == ADDR_PRESCALE);
   assign wr_slp = i_wr && (i_addr == ADDR_SLEEP);
   assign wake = lnk.sync[SYN_WAKE];

   // decoded once, so the window and the divisor agree on what was taken
   assign unlock_set = wr_pre && (i_wdata == UNLOCK_ONLY) && !unlock_r;
   assign div_wr = wr_pre && !i_wdata[UNLOCK_BIT] && unlock_r;
   assign div_ok = (i_wdata[DIV_LSB +: DIV_W] <= DIV_MAX);

   function automatic logic mode_valid(input logic [MODE_W-1:0] m);
      return (m == MODE_IDLE) || (m == MODE_ADC_NR) || (m == MODE_PWR_DOWN)
         || (m == MODE_PWR_SAVE) || (m == MODE_STANDBY);
   endfunction

   // unlock window: high for the four cycles after the setting write, or until a divisor write closes it
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         unlock_r <= 1'b0;
         unlock_cnt_r <= 3'h0;
      end else if (unlock_set) begin
         unlock_r <= 1'b1;
         unlock_cnt_r <= UNLOCK_CYC;
      end else if (div_wr) begin
         unlock_r <= 1'b0;
         unlock_cnt_r <= 3'h0;
      end else if (unlock_r) begin
         // a second unlock write lands here and only counts down
         unlock_cnt_r <= unlock_cnt_r - 3'h1;
         if (unlock_cnt_r == 3'h1) begin
            unlock_r <= 1'b0;
         end
      end
   end

   // fuse strap is caught once, after the synchroniser has settled
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         strap_cnt_r <= 2'h0;
         strap_done_r <= 1'b0;
         strap_load_r <= 1'b0;
      end else begin
         // one cycle after settling, once the synchroniser output holds the strap
         strap_load_r <= !strap_done_r && (strap_cnt_r == STRAP_SETTLE);
         if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == STRAP_SETTLE) begin
               strap_done_r <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_r <= DIV_RST_PLAIN;
         div_load_r <= 1'b0;
      end else begin
         div_load_r <= 1'b0;
         if (strap_load_r) begin
            div_r <= lnk.sync[SYN_FUSE] ? DIV_RST_FUSE : DIV_RST_PLAIN;
            div_load_r <= 1'b1;
         end else if (div_wr) begin
            // reserved codes are dropped; the unlock is still used up
            if (div_ok) begin
               div_r <= i_wdata[DIV_LSB +: DIV_W];
               div_load_r <= 1'b1;
            end
         end
      end
   end

   assign lnk.div_code = div_r;
   assign lnk.div_load = div_load_r;

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         arm_r <= 1'b0;
         mode_r <= MODE_IDLE;
      end else if (wr_slp) begin
         arm_r <= i_wdata[ARM_BIT];
         mode_r <= i_wdata[MODE_LSB +: MODE_W];
      end
   end

   // reserved mode makes the sleep instruction a no-op
   assign sleep_go = i_sleep_instr && arm_r && mode_valid(mode_r);

   always_comb begin
      state_nxt = state_r;
      wait_nxt = wait_r;
      case (state_r)
         ST_RUN: begin
            if (sleep_go) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // a wake still held from the last exit ends the next sleep at once
            if (wake) begin
               if (act_mode_r == MODE_PWR_DOWN || act_mode_r == MODE_PWR_SAVE) begin
                  state_nxt = ST_START;
                  wait_nxt = 16'(STARTUP_CYC);
               end else if (act_mode_r == MODE_STANDBY) begin
                  state_nxt = ST_START;
                  wait_nxt = STANDBY_START_CYC;
               end else begin
                  state_nxt = ST_HALT;
                  wait_nxt = WAKE_HALT_CYC;
               end
            end
         end
         ST_START: begin
            wait_nxt = wait_r - 16'h0001;
            if (wait_r <= 16'h0001) begin
               state_nxt = ST_HALT;
               wait_nxt = WAKE_HALT_CYC;
            end
         end
         ST_HALT: begin
            wait_nxt = wait_r - 16'h0001;
            if (wait_r <= 16'h0001) begin
               state_nxt = ST_RUN;
               wait_nxt = 16'h0000;
            end
         end
         default: begin
            state_nxt = ST_RUN;
            wait_nxt = 16'h0000;
         end
      endcase
   end

   // a reset anywhere in sleep lands here and the core restarts from
   // its reset vector; memories are never touched, only clocks gated
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_r <= ST_RUN;
         wait_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         wait_r <= wait_nxt;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         act_mode_r <= MODE_IDLE;
         adc_start_r <= 1'b0;
      end else begin
         adc_start_r <= 1'b0;
         if (state_r == ST_RUN && sleep_go) begin
            act_mode_r <= mode_r;
            adc_start_r <= i_adc_enabled
               && (mode_r == MODE_IDLE || mode_r == MODE_ADC_NR);
         end
      end
   end

   // handler runs only after the halt count of the wake sequence
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_go_r <= 1'b0;
      end else begin
         irq_go_r <= (state_r == ST_HALT) && (state_nxt == ST_RUN);
      end
   end

   always_comb begin
      run_mask = DOM_ALL;
      case (state_r)
         ST_RUN: begin
            run_mask = DOM_ALL;
         end
         ST_SLEEP: begin
            run_mask = DOM_NONE;
            case (act_mode_r)
               MODE_IDLE: begin
                  run_mask = DOM_ALL;
                  run_mask[DOM_CPU] = 1'b0;
                  run_mask[DOM_FLASH] = 1'b0;
               end
               MODE_ADC_NR: begin
                  run_mask = DOM_ALL;
                  run_mask[DOM_CPU] = 1'b0;
                  run_mask[DOM_FLASH] = 1'b0;
                  run_mask[DOM_IO] = 1'b0;
               end
               MODE_PWR_SAVE: begin
                  run_mask[DOM_ASY] = 1'b1;
               end
               MODE_STANDBY: begin
                  run_mask[DOM_OSC] = 1'b1;
               end
               default: begin
                  run_mask = DOM_NONE;
               end
            endcase
         end
         ST_START: begin
            // oscillator restarts; only the asynchronous domain is clocked until stable
            run_mask = DOM_NONE;
            run_mask[DOM_OSC] = 1'b1;
            run_mask[DOM_ASY] = 1'b1;
         end
         ST_HALT: begin
            run_mask = DOM_ALL;
            run_mask[DOM_CPU] = 1'b0;
            run_mask[DOM_FLASH] = 1'b0;
         end
         default: begin
            run_mask = DOM_ALL;
         end
      endcase
   end

   // every synchronous domain shares the one divided tick
   assign o_clk_en_cpu = lnk.tick && run_mask[DOM_CPU];
   assign o_clk_en_flash = lnk.tick && run_mask[DOM_FLASH];
   assign o_clk_en_io = lnk.tick && run_mask[DOM_IO];
   assign o_clk_en_adc = lnk.tick && run_mask[DOM_ADC];
   assign o_clk_en_asy = run_mask[DOM_ASY];
   assign o_osc_en = run_mask[DOM_OSC];
   assign o_core_halt = (state_r != ST_RUN);
   assign o_irq_go = irq_go_r;
   assign o_adc_auto_start = adc_start_r;

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_r <= 8'h00;
      end else if (i_rd) begin
         // reserved bits read back as zero
         rdata_r <= 8'h00;
         if (i_addr == ADDR_PRESCALE) begin
            rdata_r[UNLOCK_BIT] <= unlock_r;
            rdata_r[DIV_LSB +: DIV_W] <= div_r;
         end else if (i_addr == ADDR_SLEEP) begin
            rdata_r[ARM_BIT] <= arm_r;
            rdata_r[MODE_LSB +: MODE_W] <= mode_r;
         end
      end
   end

   assign o_rdata = rdata_r;
endmodule

// [scp_chk.sv]
`timescale 1ns/10ps
module scp_chk
   import scp_pkg::*;
#(
   parameter int STARTUP_CYC = 8
)
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_sleep_instr,
   input wire logic i_wake_irq,
   input wire logic i_adc_enabled,
   input wire logic i_reset_div8_fuse,
   input wire logic o_clk_en_cpu,
   input wire logic o_clk_en_flash,
   input wire logic o_clk_en_io,
   input wire logic o_clk_en_adc,
   input wire logic o_clk_en_asy,
   input wire logic o_osc_en,
   input wire logic o_core_halt,
   input wire logic o_irq_go,
   input wire logic o_adc_auto_start
);
   logic [3:0] smc_r;
   logic armed;
   // shadow of the sleep register, rebuilt from the bus
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         smc_r <= 4'h0;
      end else if (i_wr && i_addr == ADDR_SLEEP) begin
         smc_r <= i_wdata[3:0];
      end
   end
   assign armed = smc_r[0] && smc_r[3:1] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   a_sleep_enter: assert property (
      !o_core_halt && i_sleep_instr && armed |=> o_core_halt) else $error("sleep not entered");
   a_sleep_refuse: assert property (
      !o_core_halt && i_sleep_instr && !armed |=> !o_core_halt) else $error("sleep not refused");
   a_cpu_flash_pair: assert property (
      o_clk_en_cpu == o_clk_en_flash) else $error("cpu and flash enables differ");
   a_halt_cpu_off: assert property (
      o_core_halt |-> !o_clk_en_cpu && !o_clk_en_flash) else $error("cpu clock runs in halt");
   a_run_domains: assert property (
      !o_core_halt |-> o_clk_en_io == o_clk_en_cpu && o_clk_en_adc == o_clk_en_cpu)
      else $error("domains not divided alike");
   a_adc_start_entry: assert property (
      o_adc_auto_start |-> o_core_halt && !$past(o_core_halt)) else $error("stray adc start");
   a_adc_start_cause: assert property (
      !o_core_halt && i_sleep_instr && armed && i_adc_enabled && smc_r[3:2] == 2'b00
      |=> o_adc_auto_start) else $error("adc start missing");
   a_go_after_halt: assert property (
      o_irq_go |-> !o_core_halt && $past(o_core_halt) && $past(o_core_halt, 4))
      else $error("handler released too early");
   a_go_one_pulse: assert property (
      o_irq_go |=> !o_irq_go) else $error("resume pulse too long");
   a_div_legal: assert property (
      $past(i_rd) && $past(i_addr) == ADDR_PRESCALE |-> o_rdata[3:0] <= DIV_MAX
      && o_rdata[6:4] == 3'h0) else $error("illegal divisor read back");
   c_wake: cover property (o_irq_go);
   c_adc_start: cover property (o_adc_auto_start);
   c_deep_sleep: cover property ($rose(o_core_halt) ##1 !o_clk_en_asy);
endmodule

// [scp_core_model.sv]
`timescale 1ns/10ps
module scp_core_model
   import scp_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic [7:0] i_rdata,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   output logic o_sleep_instr
);
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_sleep_instr = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_ref_clk);
      o_wr <= 1'b0;
      // released data must not look valid
      o_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_ref_clk);
      o_rd <= 1'b0;
      #1;
      d = i_rdata;
   endtask
   // two writes back to back, nothing may slip in between
   task automatic unlock_div(input logic [3:0] c);
      wr(ADDR_PRESCALE, UNLOCK_ONLY);
      wr(ADDR_PRESCALE, {4'h0, c});
   endtask
   task automatic sleep();
      @(posedge i_ref_clk);
      o_sleep_instr <= 1'b1;
      @(posedge i_ref_clk);
      o_sleep_instr <= 1'b0;
   endtask
endmodule

// [sysclk_prescaler_sleep_ctrl_bench.sv]
`timescale 1ns/10ps
module sysclk_prescaler_sleep_ctrl_bench;
   import scp_pkg::*;
   localparam int SU = 8;
   logic i_ref_clk, i_rstn, i_wr, i_rd, i_sleep_instr, i_wake_irq, i_adc_enabled;
   logic i_reset_div8_fuse, o_clk_en_cpu, o_clk_en_flash, o_clk_en_io, o_clk_en_adc;
   logic o_clk_en_asy, o_osc_en, o_core_halt, o_irq_go, o_adc_auto_start;
   logic [7:0] i_addr, i_wdata, o_rdata, rexp, lf, d;
   logic [3:0] div_m, slp_m;
   int miscompares, checked, win_m, w, cnt, old;
   logic [2:0] md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
   logic [5:0] mk [5] = '{6'h3c, 6'h38, 6'h00, 6'h10, 6'h20};
   int st [5] = '{0, 0, SU, SU, 6};
   logic [7:0] bad [4] = '{8'h09, 8'h00, 8'h0b, 8'h0f};
   scp_core_model core (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd), .o_sleep_instr(i_sleep_instr));
   scp_top #(.STARTUP_CYC(SU)) uut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_sleep_instr(i_sleep_instr), .i_wake_irq(i_wake_irq), .i_adc_enabled(i_adc_enabled),
      .i_reset_div8_fuse(i_reset_div8_fuse), .o_clk_en_cpu(o_clk_en_cpu),
      .o_clk_en_flash(o_clk_en_flash), .o_clk_en_io(o_clk_en_io), .o_clk_en_adc(o_clk_en_adc),
      .o_clk_en_asy(o_clk_en_asy), .o_osc_en(o_osc_en), .o_core_halt(o_core_halt),
      .o_irq_go(o_irq_go), .o_adc_auto_start(o_adc_auto_start));
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // reference model of both registers, fed from the bus itself
   always @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_m = i_reset_div8_fuse ? DIV_RST_FUSE : DIV_RST_PLAIN;
         win_m = 0;
         slp_m = 4'h0;
      end else begin
         w = win_m;
         if (i_rd) begin
            rexp = i_addr == ADDR_PRESCALE ? {w > 0, 3'h0, div_m} :
               i_addr == ADDR_SLEEP ? {4'h0, slp_m} : 8'h00;
         end
         if (win_m > 0) win_m--;
         if (i_wr && i_addr == ADDR_SLEEP) slp_m = i_wdata[3:0];
         if (i_wr && i_addr == ADDR_PRESCALE) begin
            if (i_wdata == UNLOCK_ONLY) begin
               if (w == 0) win_m = 4;
            end else if (!i_wdata[7] && w > 0) begin
               if (i_wdata[3:0] <= DIV_MAX) div_m = i_wdata[3:0];
               win_m = 0;
            end
         end
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a);
      core.rd(a, d);
      chk(d, rexp, "rdata");
   endtask
   // cycles up to the next divided tick
   task automatic per();
      cnt = 0;
      do begin
         @(posedge i_ref_clk);
         #1;
         cnt++;
      end while (o_clk_en_io !== 1'b1 && cnt < 600);
   endtask
   task automatic reset_dut(input logic f);
      @(posedge i_ref_clk);
      i_rstn <= 1'b0;
      i_reset_div8_fuse <= f;
      repeat (5) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      // strap settles before the first access
      repeat (7) @(posedge i_ref_clk);
   endtask
   task close_out();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge i_ref_clk);
      miscompares++;
      close_out();
   end
   initial begin
      i_rstn = 1'b0;
      i_wake_irq = 1'b0;
      i_adc_enabled = 1'b0;
      i_reset_div8_fuse = 1'b1;
      lf = 8'h01;
      miscompares = 0;
      checked = 0;
      reset_dut(1'b1);
      rchk(ADDR_PRESCALE);
      core.unlock_div(4'h0);
      rchk(ADDR_PRESCALE);
      reset_dut(1'b0);
      rchk(ADDR_PRESCALE);
      rchk(8'h5a);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         core.wr(ADDR_PRESCALE, lf | 8'h81);
         core.wr(ADDR_PRESCALE, 8'h02);
         rchk(ADDR_PRESCALE);
      end
      core.wr(ADDR_PRESCALE, UNLOCK_ONLY);
      core.wr(ADDR_PRESCALE, UNLOCK_ONLY);
      rchk(ADDR_PRESCALE);
      core.wr(ADDR_PRESCALE, 8'h05);
      rchk(ADDR_PRESCALE);
      core.unlock_div(4'h9);
      rchk(ADDR_PRESCALE);
      for (int c = 0; c <= 8; c++) begin
         old = 1 << div_m;
         core.unlock_div(c[3:0]);
         per();
         repeat (3) begin
            per();
            chk(cnt >= (old < (1 << c) ? old : (1 << c)), 1, "gap");
         end
         chk(cnt, 1 << c, "period");
         rchk(ADDR_PRESCALE);
      end
      core.unlock_div(4'h0);
      // the divide-by-256 period must run out before the domains are compared
      repeat (2) per();
      for (int k = 0; k < 5; k++) begin
         lf = lfsr(lf);
         @(posedge i_ref_clk);
         i_adc_enabled <= lf[0];
         core.wr(ADDR_SLEEP, {4'h0, md[k], 1'b1});
         core.sleep();
         #1;
         chk(o_core_halt, 1, "halt");
         chk(o_adc_auto_start, lf[0] && md[k] < 3'h2, "adc start");
         @(posedge i_ref_clk);
         #1;
         chk({o_osc_en, o_clk_en_asy, o_clk_en_adc, o_clk_en_io, o_clk_en_flash,
            o_clk_en_cpu}, mk[k], "domains");
         @(posedge i_ref_clk);
         i_wake_irq <= 1'b1;
         cnt = 0;
         while (o_irq_go !== 1'b1 && cnt < 100) begin
            @(posedge i_ref_clk);
            #1;
            cnt++;
         end
         i_wake_irq <= 1'b0;
         chk(cnt >= 4 + st[k] && cnt <= 12 + st[k], 1, "wake time");
         rchk(ADDR_SLEEP);
      end
      for (int k = 0; k < 4; k++) begin
         core.wr(ADDR_SLEEP, bad[k]);
         core.sleep();
         #1;
         chk(o_core_halt, 0, "refused halt");
      end
      core.wr(ADDR_SLEEP, 8'h05);
      core.sleep();
      reset_dut(1'b0);
      chk(o_core_halt, 0, "halt after reset");
      rchk(ADDR_SLEEP);
      close_out();
   end
endmodule
bind scp_top scp_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (.i_ref_clk(i_ref_clk),
   .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_sleep_instr(i_sleep_instr), .i_wake_irq(i_wake_irq),
   .i_adc_enabled(i_adc_enabled), .i_reset_div8_fuse(i_reset_div8_fuse),
   .o_clk_en_cpu(o_clk_en_cpu), .o_clk_en_flash(o_clk_en_flash), .o_clk_en_io(o_clk_en_io),
   .o_clk_en_adc(o_clk_en_adc), .o_clk_en_asy(o_clk_en_asy), .o_osc_en(o_osc_en),
   .o_core_halt(o_core_halt), .o_irq_go(o_irq_go), .o_adc_auto_start(o_adc_auto_start));
